// >>> rtl/dir_oc_pkg.sv
// shared constants for the directional overcurrent timing block
`default_nettype none
package dir_oc_pkg;
   // ----------------------------------------
   // timing
   // ----------------------------------------
   localparam int CLK_PERIOD_NS = 100;
   localparam int TICK_TIME_NS = 1000000;
   localparam int TICK_CYCLES = (TICK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // ----------------------------------------
   // structure
   // ----------------------------------------
   localparam int NCH = 4;
   localparam int CH_GND = 3;
   localparam int CURVE_PTS = 20;
   localparam int ADDR_W = 12;
   // ----------------------------------------
   // register offsets
   // ----------------------------------------
   localparam logic [11:0] ADDR_CTRL = 12'h000;
   localparam logic [11:0] ADDR_DEF_THR_PH = 12'h004;
   localparam logic [11:0] ADDR_DEF_THR_GND = 12'h008;
   localparam logic [11:0] ADDR_DEF_DLY_PH = 12'h00C;
   localparam logic [11:0] ADDR_DEF_DLY_GND = 12'h010;
   localparam logic [11:0] ADDR_HOLD_PH = 12'h014;
   localparam logic [11:0] ADDR_HOLD_GND = 12'h018;
   localparam logic [11:0] ADDR_INV_THR_PH = 12'h01C;
   localparam logic [11:0] ADDR_INV_THR_GND = 12'h020;
   localparam logic [11:0] ADDR_TM = 12'h024;
   localparam logic [11:0] ADDR_INOM = 12'h028;
   localparam logic [11:0] ADDR_CURVE_CFG = 12'h02C;
   localparam logic [11:0] ADDR_STATUS = 12'h030;
   localparam logic [11:0] ADDR_TABLE = 12'h040;
   localparam logic [11:0] ADDR_TABLE_LAST = 12'h08C;
   // ----------------------------------------
   // control field positions
   // ----------------------------------------
   localparam int CTRL_INRUSH_EN = 0;
   localparam int CTRL_DIR_PH = 1;
   localparam int CTRL_DIR_GND = 2;
   localparam int CTRL_DISK_PH = 3;
   localparam int CTRL_DISK_GND = 4;
   localparam int CTRL_USER_PH = 5;
   localparam int CTRL_USER_GND = 6;
   localparam int CTRL_USER_DROP = 7;
   localparam int CFG_NPTS_LSB = 16;
   // ----------------------------------------
   // reset values
   // ----------------------------------------
   localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
   localparam logic [15:0] THR_RESET = 16'h0100;
   localparam logic [15:0] DLY_RESET = 16'h0064;
   localparam logic [15:0] HOLD_RESET = 16'h0000;
   localparam logic [15:0] TM_RESET = 16'h0010;
   localparam logic [15:0] INOM_RESET = 16'h0100;
   localparam logic [15:0] STEP_RESET = 16'h0001;
   localparam logic [4:0] NPTS_RESET = 5'h00;
   localparam int TM_SHIFT = 4;
   // ----------------------------------------
   // direction verdict codes and bus answers
   // ----------------------------------------
   localparam logic [1:0] DIR_UNDET = 2'h0;
   localparam logic [1:0] DIR_FWD = 2'h1;
   localparam logic [1:0] DIR_REV = 2'h2;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : dir_oc_pkg
`default_nettype wire

// >>> rtl/inverse_integrator.sv
// one channel of the inverse-time pickup and time counter
`default_nettype none
module inverse_integrator (
   input wire logic clk,
   input wire logic reset,
   input wire logic tick,
   input wire logic [15:0] cur,
   input wire logic [15:0] thr,
   input wire logic dir_ok,
   input wire logic [31:0] delay,
   input wire logic disk,
   input wire logic [15:0] step,
   input wire logic blocked,
   output logic picked,
   output logic expired
);
   import dir_oc_pkg::*;

   typedef struct packed {
      logic picked;
      logic [31:0] acc;
      logic expired;
   } state_s;

   state_s state_reg;
   state_s state_next;
   logic pick_lvl;
   logic rel95;
   logic below90;

   // ----------------------------------------
   // levels
   // ----------------------------------------
   // RULE13 pickup at 1.1 times
   assign pick_lvl = ({16'h0000, cur} * 32'h0000_000A) > ({16'h0000, thr} * 32'h0000_000B);
   // RULE18 release near 95 percent
   assign rel95 = ({16'h0000, cur} * 32'h0000_0014) < ({16'h0000, thr} * 32'h0000_0013);
   assign below90 = ({16'h0000, cur} * 32'h0000_000A) < ({16'h0000, thr} * 32'h0000_0009);

   always_comb begin
      state_next = state_reg;
      state_next.picked = dir_ok & (state_reg.picked ? !rel95 : pick_lvl);
      if (blocked) begin
         // RULE23 restart after unblock
         state_next.acc = 32'h0000_0000;
      end else if (state_next.picked) begin
         // RULE14 integrate while picked
         if (tick && state_reg.acc < delay) begin
            state_next.acc = state_reg.acc + 32'h0000_0001;
         end
      end else if (!disk) begin
         // RULE22 restart from zero
         state_next.acc = 32'h0000_0000;
      end else if (tick && below90) begin
         // RULE19 disk reset below 90
         state_next.acc = (state_reg.acc > {16'h0000, step}) ? state_reg.acc - {16'h0000, step} : 32'h0000_0000;
      end
      // RULE20 idle between 95 and 90
      state_next.expired = state_next.picked && (state_next.acc >= delay);
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign picked = state_reg.picked;
   assign expired = state_reg.expired;
endmodule : inverse_integrator
`default_nettype wire

// >>> rtl/dir_overcurrent.sv
// directional definite-time and inverse-time overcurrent timing with axi4-lite registers
// Operation
// RULE1 - definite pickup: above threshold, direction matches
// RULE2 - inrush picks inrush pickup instead of normal
// RULE3 - trip once definite delay fully elapsed
// RULE4 - inrush at expiry: no trip, timeout flag
// RULE5 - separate trip and timeout per element
// RULE6 - release at 95 percent above 0.3 nominal
// RULE7 - below threshold: dropout hold keeps pickup
// RULE8 - hold expiry clears pickup and delay
// RULE9 - exceeding again cancels dropout hold
// RULE10 - expired delay trips at renewed excess
// RULE11 - hold only without inrush; inrush resets
// RULE12 - auto reclose may block definite elements
// RULE13 - inverse pickup at 1.1 times, per phase
// RULE14 - integrate delay from current and curve
// RULE15 - inverse trip only without restrained inrush
// RULE16 - ground curve, thresholds, multipliers set separately
// RULE17 - choose instantaneous or disk emulation dropout
// RULE18 - instantaneous: release 95 percent, restart zero
// RULE19 - disk: decrement below 90 percent, keep history
// RULE20 - disk: hold counter between 95 and 90
// RULE21 - user curve: 20 pairs, linear interpolation
// RULE22 - no user dropout: release 95, restart
// RULE23 - unblocking restarts the time delays
// RULE24 - blocked: no trip, pickup still evaluated
// RULE25 - undetermined direction never counts as match
`default_nettype none
module dir_overcurrent #(
   parameter int TICK_CYCLES = dir_oc_pkg::TICK_CYCLES
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic [dir_oc_pkg::ADDR_W-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [dir_oc_pkg::ADDR_W-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic [3:0][15:0] cur_mag,
   input wire logic [1:0] dir_phase,
   input wire logic [1:0] dir_ground,
   input wire logic [3:0] inrush_det,
   input wire logic [3:0][15:0] std_curve_delay,
   input wire logic reclose_block_def,
   input wire logic reclose_block_inv,
   output logic [3:0] def_pickup,
   output logic [3:0] def_inrush_pickup,
   output logic [1:0] def_trip,
   output logic [1:0] def_timeout,
   output logic [3:0] inv_pickup,
   output logic [3:0] inv_inrush_pickup,
   output logic [1:0] inv_trip,
   output logic [1:0] inv_timeout
);
   import dir_oc_pkg::*;

   typedef struct packed {
      logic awgot;
      logic [ADDR_W-1:0] awaddr;
      logic wgot;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic [31:0] ctrl;
      logic [1:0][15:0] def_thr;
      logic [1:0][15:0] def_dly;
      logic [1:0][15:0] hold;
      logic [1:0][15:0] inv_thr;
      logic [1:0][15:0] tm;
      logic [15:0] inom;
      logic [15:0] step;
      logic [4:0] npts;
      logic [CURVE_PTS-1:0][31:0] curve;
      logic [23:0] tick_cnt;
      logic tick;
      logic [3:0] meas;
      logic [3:0] pu;
      logic [3:0] drun;
      logic [3:0][15:0] dcnt;
      logic [3:0][15:0] tcnt;
      logic [3:0] def_pu;
      logic [3:0] def_ipu;
      logic [3:0] inv_pu;
      logic [3:0] inv_ipu;
      logic [1:0] def_trip;
      logic [1:0] def_tmo;
      logic [1:0] inv_trip;
      logic [1:0] inv_tmo;
   } state_s;

   state_s state_reg;
   state_s state_next;
   logic [3:0] dir_ok;
   logic [3:0] above;
   logic [3:0] rel;
   logic [3:0] inr;
   logic [3:0] inv_pick;
   logic [3:0] inv_exp;
   logic [3:0][15:0] hold_ch;
   logic [3:0][15:0] dly_ch;

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val, input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            r[8*b +: 8] = val[8*b +: 8];
         end
      end
      return r;
   endfunction : merge

   // RULE21 piecewise linear user curve
   function automatic logic [15:0] interp(input logic [15:0] cur, input logic [CURVE_PTS-1:0][31:0] tbl,
                                          input logic [4:0] npts);
      logic [15:0] res;
      logic signed [16:0] diff;
      logic signed [33:0] prod;
      logic signed [33:0] quot;
      res = tbl[0][31:16];
      diff = '0;
      prod = '0;
      quot = '0;
      for (int k = 0; k < CURVE_PTS - 1; k++) begin
         if (5'(k + 1) < npts && cur >= tbl[k+1][15:0]) begin
            res = tbl[k+1][31:16];
         end else if (5'(k + 1) < npts && cur >= tbl[k][15:0] && cur < tbl[k+1][15:0]) begin
            diff = $signed({1'b0, tbl[k+1][31:16]}) - $signed({1'b0, tbl[k][31:16]});
            prod = 34'(diff * $signed({1'b0, cur - tbl[k][15:0]}));
            quot = prod / $signed({18'h00000, tbl[k+1][15:0] - tbl[k][15:0]});
            res = 16'($signed({18'h00000, tbl[k][31:16]}) + quot);
         end
      end
      return res;
   endfunction : interp

   // ----------------------------------------
   // per channel levels and inverse counters
   // ----------------------------------------
   for (genvar c = 0; c < NCH; c++) begin : g_ch
      localparam int EL = (c == CH_GND) ? 1 : 0;
      logic [1:0] verdict;
      logic want_rev;
      logic user;
      logic [15:0] curve_dly;
      logic [31:0] eff_dly;
      assign verdict = (c == CH_GND) ? dir_ground : dir_phase;
      assign want_rev = state_reg.ctrl[(c == CH_GND) ? CTRL_DIR_GND : CTRL_DIR_PH];
      // RULE25 undetermined never matches
      assign dir_ok[c] = (verdict == (want_rev ? DIR_REV : DIR_FWD)) && (verdict != DIR_UNDET);
      // RULE1 separate threshold compare
      assign above[c] = cur_mag[c] > state_reg.def_thr[EL];
      // RULE6 95 percent release above 0.3 nominal
      assign rel[c] = (({16'h0000, cur_mag[c]} * 32'h0000_000A) > ({16'h0000, state_reg.inom} * 32'h0000_0003)) ?
                      (({16'h0000, cur_mag[c]} * 32'h0000_0014) < ({16'h0000, state_reg.def_thr[EL]} * 32'h0000_0013)) :
                      !above[c];
      assign inr[c] = inrush_det[c] & state_reg.ctrl[CTRL_INRUSH_EN];
      assign hold_ch[c] = state_reg.hold[EL];
      assign dly_ch[c] = state_reg.def_dly[EL];
      // RULE16 independent ground curve
      assign user = state_reg.ctrl[(c == CH_GND) ? CTRL_USER_GND : CTRL_USER_PH];
      assign curve_dly = user ? interp(cur_mag[c], state_reg.curve, state_reg.npts) : std_curve_delay[c];
      assign eff_dly = ({16'h0000, curve_dly} * {16'h0000, state_reg.tm[EL]}) >> TM_SHIFT;
      inverse_integrator u_inv (
         .clk(clk),
         .reset(reset),
         .tick(state_reg.tick),
         .cur(cur_mag[c]),
         .thr(state_reg.inv_thr[EL]),
         .dir_ok(dir_ok[c]),
         .delay(eff_dly),
         // RULE17 dropout mode select
         .disk(user ? state_reg.ctrl[CTRL_USER_DROP] : state_reg.ctrl[(c == CH_GND) ? CTRL_DISK_GND : CTRL_DISK_PH]),
         .step(state_reg.step),
         .blocked(reclose_block_inv),
         .picked(inv_pick[c]),
         .expired(inv_exp[c])
      );
   end

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      state_next = state_reg;
      // sample tick; long period so a bench may shorten it
      state_next.tick = 1'b0;
      if (state_reg.tick_cnt >= 24'(TICK_CYCLES - 1)) begin
         state_next.tick_cnt = 24'h000000;
         state_next.tick = 1'b1;
      end else begin
         state_next.tick_cnt = state_reg.tick_cnt + 24'h000001;
      end

      // write channel: address and data may come in either order
      if (awvalid && awready) begin
         state_next.awgot = 1'b1;
         state_next.awaddr = awaddr;
      end
      if (wvalid && wready) begin
         state_next.wgot = 1'b1;
         state_next.wdata = wdata;
         state_next.wstrb = wstrb;
      end
      if (bvalid && bready) begin
         state_next.bvalid = 1'b0;
      end
      if (state_reg.awgot && state_reg.wgot) begin
         state_next.awgot = 1'b0;
         state_next.wgot = 1'b0;
         state_next.bvalid = 1'b1;
         state_next.bresp = RESP_OKAY;
         case (state_reg.awaddr)
            ADDR_CTRL: state_next.ctrl = merge(state_reg.ctrl, state_reg.wdata, state_reg.wstrb);
            ADDR_DEF_THR_PH: state_next.def_thr[0] = 16'(merge({16'h0000, state_reg.def_thr[0]}, state_reg.wdata, state_reg.wstrb));
            ADDR_DEF_THR_GND: state_next.def_thr[1] = 16'(merge({16'h0000, state_reg.def_thr[1]}, state_reg.wdata, state_reg.wstrb));
            ADDR_DEF_DLY_PH: state_next.def_dly[0] = 16'(merge({16'h0000, state_reg.def_dly[0]}, state_reg.wdata, state_reg.wstrb));
            ADDR_DEF_DLY_GND: state_next.def_dly[1] = 16'(merge({16'h0000, state_reg.def_dly[1]}, state_reg.wdata, state_reg.wstrb));
            ADDR_HOLD_PH: state_next.hold[0] = 16'(merge({16'h0000, state_reg.hold[0]}, state_reg.wdata, state_reg.wstrb));
            ADDR_HOLD_GND: state_next.hold[1] = 16'(merge({16'h0000, state_reg.hold[1]}, state_reg.wdata, state_reg.wstrb));
            ADDR_INV_THR_PH: state_next.inv_thr[0] = 16'(merge({16'h0000, state_reg.inv_thr[0]}, state_reg.wdata, state_reg.wstrb));
            ADDR_INV_THR_GND: state_next.inv_thr[1] = 16'(merge({16'h0000, state_reg.inv_thr[1]}, state_reg.wdata, state_reg.wstrb));
            ADDR_TM: state_next.tm = merge(state_reg.tm, state_reg.wdata, state_reg.wstrb);
            ADDR_INOM: state_next.inom = 16'(merge({16'h0000, state_reg.inom}, state_reg.wdata, state_reg.wstrb));
            ADDR_CURVE_CFG: {state_next.npts, state_next.step} =
               21'(merge({11'h000, state_reg.npts, state_reg.step}, state_reg.wdata, state_reg.wstrb));
            default: begin
               if (state_reg.awaddr >= ADDR_TABLE && state_reg.awaddr <= ADDR_TABLE_LAST && state_reg.awaddr[1:0] == 2'h0) begin
                  state_next.curve[5'((state_reg.awaddr - ADDR_TABLE) >> 2)] =
                     merge(state_reg.curve[5'((state_reg.awaddr - ADDR_TABLE) >> 2)], state_reg.wdata, state_reg.wstrb);
               end else begin
                  state_next.bresp = RESP_SLVERR;
               end
            end
         endcase
      end

      // read channel
      if (rvalid && rready) begin
         state_next.rvalid = 1'b0;
      end
      if (arvalid && arready) begin
         state_next.rvalid = 1'b1;
         state_next.rresp = RESP_OKAY;
         case (araddr)
            ADDR_CTRL: state_next.rdata = state_reg.ctrl;
            ADDR_DEF_THR_PH: state_next.rdata = {16'h0000, state_reg.def_thr[0]};
            ADDR_DEF_THR_GND: state_next.rdata = {16'h0000, state_reg.def_thr[1]};
            ADDR_DEF_DLY_PH: state_next.rdata = {16'h0000, state_reg.def_dly[0]};
            ADDR_DEF_DLY_GND: state_next.rdata = {16'h0000, state_reg.def_dly[1]};
            ADDR_HOLD_PH: state_next.rdata = {16'h0000, state_reg.hold[0]};
            ADDR_HOLD_GND: state_next.rdata = {16'h0000, state_reg.hold[1]};
            ADDR_INV_THR_PH: state_next.rdata = {16'h0000, state_reg.inv_thr[0]};
            ADDR_INV_THR_GND: state_next.rdata = {16'h0000, state_reg.inv_thr[1]};
            ADDR_TM: state_next.rdata = state_reg.tm;
            ADDR_INOM: state_next.rdata = {16'h0000, state_reg.inom};
            ADDR_CURVE_CFG: state_next.rdata = {11'h000, state_reg.npts, state_reg.step};
            ADDR_STATUS: state_next.rdata = {8'h00, state_reg.inv_tmo, state_reg.inv_trip, state_reg.def_tmo,
                                             state_reg.def_trip, state_reg.inv_ipu, state_reg.inv_pu,
                                             state_reg.def_ipu, state_reg.def_pu};
            default: begin
               if (araddr >= ADDR_TABLE && araddr <= ADDR_TABLE_LAST && araddr[1:0] == 2'h0) begin
                  state_next.rdata = state_reg.curve[5'((araddr - ADDR_TABLE) >> 2)];
               end else begin
                  state_next.rdata = 32'h0000_0000;
                  state_next.rresp = RESP_SLVERR;
               end
            end
         endcase
      end

      // definite-time elements and inverse outputs
      state_next.def_trip = 2'h0;
      state_next.def_tmo = 2'h0;
      state_next.inv_trip = 2'h0;
      state_next.inv_tmo = 2'h0;
      for (int c = 0; c < NCH; c++) begin
         // RULE1 pickup with hysteresis
         state_next.meas[c] = dir_ok[c] & (state_reg.meas[c] ? !rel[c] : above[c]);
         // RULE12 reclose block holds delay at zero
         if (reclose_block_def) begin
            state_next.tcnt[c] = 16'h0000;
         // RULE7 delay keeps running during hold
         end else if (state_reg.pu[c] && state_reg.tick && state_reg.tcnt[c] < dly_ch[c]) begin
            state_next.tcnt[c] = state_reg.tcnt[c] + 16'h0001;
         end
         if (state_next.meas[c]) begin
            // RULE9 renewed excess cancels hold
            state_next.pu[c] = 1'b1;
            state_next.drun[c] = 1'b0;
            state_next.dcnt[c] = 16'h0000;
         end else if (state_reg.pu[c]) begin
            // RULE11 inrush resets hold
            if (inr[c] || hold_ch[c] == 16'h0000) begin
               state_next.pu[c] = 1'b0;
               state_next.drun[c] = 1'b0;
               state_next.tcnt[c] = 16'h0000;
            end else if (!state_reg.drun[c]) begin
               // RULE7 start dropout hold
               state_next.drun[c] = 1'b1;
               state_next.dcnt[c] = 16'h0000;
            end else if (state_reg.tick) begin
               if (state_reg.dcnt[c] + 16'h0001 >= hold_ch[c]) begin
                  // RULE8 hold expiry clears pickup and delay
                  state_next.pu[c] = 1'b0;
                  state_next.drun[c] = 1'b0;
                  state_next.tcnt[c] = 16'h0000;
               end else begin
                  state_next.dcnt[c] = state_reg.dcnt[c] + 16'h0001;
               end
            end
         end
         // RULE2 normal or inrush pickup
         state_next.def_pu[c] = state_next.pu[c] & !inr[c];
         state_next.def_ipu[c] = state_next.pu[c] & inr[c];
         state_next.inv_pu[c] = inv_pick[c] & !inr[c];
         state_next.inv_ipu[c] = inv_pick[c] & inr[c];
         if (state_reg.pu[c] && state_reg.tcnt[c] >= dly_ch[c] && !reclose_block_def) begin
            // RULE3 RULE10 RULE24 trip on live excess
            if (state_reg.meas[c] && !inr[c]) begin
               state_next.def_trip[(c == CH_GND) ? 1 : 0] = 1'b1;
            end
            // RULE4 inrush gives timeout only
            if (inr[c]) begin
               state_next.def_tmo[(c == CH_GND) ? 1 : 0] = 1'b1;
            end
         end
         // RULE15 inverse trip unless inrush
         if (inv_exp[c] && !reclose_block_inv) begin
            if (!inr[c]) begin
               state_next.inv_trip[(c == CH_GND) ? 1 : 0] = 1'b1;
            end else begin
               state_next.inv_tmo[(c == CH_GND) ? 1 : 0] = 1'b1;
            end
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         state_reg <= '0;
         state_reg.ctrl <= CTRL_RESET;
         state_reg.def_thr <= {THR_RESET, THR_RESET};
         state_reg.def_dly <= {DLY_RESET, DLY_RESET};
         state_reg.hold <= {HOLD_RESET, HOLD_RESET};
         state_reg.inv_thr <= {THR_RESET, THR_RESET};
         state_reg.tm <= {TM_RESET, TM_RESET};
         state_reg.inom <= INOM_RESET;
         state_reg.step <= STEP_RESET;
         state_reg.npts <= NPTS_RESET;
      end else begin
         state_reg <= state_next;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign awready = !state_reg.awgot && !state_reg.bvalid;
   assign wready = !state_reg.wgot && !state_reg.bvalid;
   assign bvalid = state_reg.bvalid;
   assign bresp = state_reg.bresp;
   assign arready = !state_reg.rvalid;
   assign rvalid = state_reg.rvalid;
   assign rdata = state_reg.rdata;
   assign rresp = state_reg.rresp;
   assign def_pickup = state_reg.def_pu;
   assign def_inrush_pickup = state_reg.def_ipu;
   // RULE5 trip and timeout apart
   assign def_trip = state_reg.def_trip;
   assign def_timeout = state_reg.def_tmo;
   assign inv_pickup = state_reg.inv_pu;
   assign inv_inrush_pickup = state_reg.inv_ipu;
   assign inv_trip = state_reg.inv_trip;
   assign inv_timeout = state_reg.inv_tmo;
endmodule : dir_overcurrent
`default_nettype wire

// >>> test/front_end_model.sv
// far-side model: currents, direction verdicts, inrush flags
`default_nettype none
module front_end_model (input wire logic clk, input wire logic [18:0] stim, output logic [3:0][15:0] cur_mag,
   output logic [1:0] dir_phase, dir_ground, output logic [3:0] inrush_det);
   timeunit 1ns / 1ns;
   always_ff @(posedge clk)
      {cur_mag, dir_phase, dir_ground, inrush_det} <= {stim[18:3], 48'h0, {2{stim[2:1]}}, {4{stim[0]}}};
endmodule : front_end_model
`default_nettype wire

// >>> test/dir_oc_monitor.sv
// port checker for the overcurrent block
`default_nettype none
module dir_oc_monitor (input wire logic clk, reset, reclose_block_def, reclose_block_inv,
   input wire logic [1:0] dir_ground, def_trip, inv_trip, input wire logic [3:0] inrush_det, def_pickup, inv_pickup);
   timeunit 1ns / 1ns;
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   AST_UNDET: assert property (dir_ground == 2'h0 |-> ##2 !inv_pickup[3]) else $error("undetermined pickup");
   AST_TRIP: assert property (def_trip[1] |-> $past(def_pickup[3])) else $error("trip without pickup");
   AST_BLKD: assert property (reclose_block_def [*2] |-> def_trip == 2'h0) else $error("blocked trip");
   AST_BLKI: assert property (reclose_block_inv [*2] |-> inv_trip == 2'h0) else $error("blocked trip");
   AST_INRD: assert property (inrush_det[3] |=> !def_pickup[3]) else $error("normal pickup");
   AST_INRI: assert property (inrush_det[3] |=> !inv_pickup[3]) else $error("normal pickup");
   AST_TMOD: assert property (inrush_det[3] [*3] |-> !def_trip[1]) else $error("inrush trip");
   AST_TMOI: assert property (inrush_det[3] [*3] |-> !inv_trip[1]) else $error("inrush trip");
endmodule : dir_oc_monitor
bind dir_overcurrent dir_oc_monitor dir_oc_monitor_i (.*);
`default_nettype wire

// >>> test/tb.sv
// self-checking bench for the overcurrent block
`default_nettype none
module tb;
   timeunit 1ns / 1ns;
   import dir_oc_pkg::*;
   logic clk = 1'h0, reset = 1'h1, awvalid = 1'h0, wvalid = 1'h0, arvalid = 1'h0, bready = 1'h1, rready = 1'h1;
   logic reclose_block_def = 1'h0, reclose_block_inv = 1'h0, awready, wready, bvalid, arready, rvalid;
   logic [11:0] awaddr = 12'h0, araddr = 12'h0;
   logic [31:0] wdata = 32'h0, rdata;
   logic [3:0] wstrb = 4'hF, inrush_det, def_pickup, def_inrush_pickup, inv_pickup, inv_inrush_pickup;
   logic [1:0] bresp, rresp, dir_phase, dir_ground, def_trip, def_timeout, inv_trip, inv_timeout;
   logic [3:0][15:0] cur_mag, std_curve_delay = {4{16'hFFFF}}; // huge curve delay: no inverse trip
   logic [18:0] stim = 19'h2;
   logic [33:0] q[$];
   int fail_count = 0, comparisons = 0;
   dir_overcurrent #(.TICK_CYCLES(4)) dir_overcurrent_i (.*);
   front_end_model front_end_model_i (.*);
   initial forever #50 clk = ~clk;
   initial #400000 wrap_up(1);
   always @(posedge clk) if (rvalid) chk({rresp, rdata}, q.pop_front());
   task chk(input logic [33:0] s, e);
      comparisons++;
      fail_count += int'(s !== e);
      if (s !== e) $display("CHECK FAILED %0t got %h exp %h", $time, s, e);
   endtask : chk
   task wr(input logic [11:0] a, input logic [31:0] d);
      {awaddr, wdata, awvalid, wvalid} <= {a, d, 2'h3};
      do begin
         @(posedge clk);
         if (awready) awvalid <= 1'h0;
         if (wready) wvalid <= 1'h0;
      end while (awvalid || wvalid);
      do @(posedge clk); while (!bvalid);
   endtask : wr
   task rd(input logic [11:0] a, input logic [33:0] e);
      q.push_back(e);
      {araddr, arvalid} <= {a, 1'h1};
      do @(posedge clk); while (!arready);
      arvalid <= 1'h0;
      do @(posedge clk); while (!rvalid);
   endtask : rd
   task drive(input logic [18:0] s, input logic b, input int n);
      stim <= s;
      {reclose_block_def, reclose_block_inv} <= {b, b};
      repeat (n) @(posedge clk);
   endtask : drive
   task wrap_up(input int extra);
      fail_count += extra;
      $display("fail_count %0d comparisons %0d", fail_count, comparisons);
      if (fail_count == 0 && comparisons > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : wrap_up
   initial begin
      repeat (2) @(posedge clk);
      reset <= 1'h0;
      void'($urandom(12328));
      rd(ADDR_CTRL, {RESP_OKAY, CTRL_RESET});
      rd(12'h100, {RESP_SLVERR, 32'h0});
      drive({16'h200 + 16'($urandom % 16'h1000), 3'h2}, 1'h0, 450);
      rd(ADDR_STATUS, 34'h20808);
      for (int i = 0; i < 3; i += 2) begin
         drive({16'h300, 2'(i), 1'h0}, 1'h0, 20);
         rd(ADDR_STATUS, 34'h0);
      end
      drive({16'h300, 3'h3}, 1'h0, 450);
      rd(ADDR_STATUS, 34'h88080);
      chk(34'({def_timeout, def_inrush_pickup, inv_inrush_pickup}), 34'h288);
      drive({16'h300, 3'h2}, 1'h1, 450);
      rd(ADDR_STATUS, 34'h808);
      chk(34'({inv_pickup, def_pickup, def_trip}), 34'h220);
      drive({16'h300, 3'h2}, 1'h0, 3);
      chk(34'(def_trip), 34'h0);
      wr(ADDR_HOLD_GND, 32'h5);
      drive(19'h2, 1'h0, 4);
      chk(34'(def_pickup[3]), 34'h1);
      drive(19'h2, 1'h0, 40);
      chk(34'(def_pickup[3]), 34'h0);
      // short ground curve: five ticks at unity multiplier
      std_curve_delay[3] <= 16'h0005;
      drive({16'h300, 3'h3}, 1'h0, 40);
      chk(34'({inv_timeout, inv_trip}), 34'h8);
      drive({16'h300, 3'h2}, 1'h0, 4);
      chk(34'({inv_timeout, inv_trip}), 34'h2);
      wrap_up(0);
   end
endmodule : tb
`default_nettype wire
